// ### elem_model.sv
// Model of the protective elements and their fault pins
`timescale 1ns/1ns
module elem_model
(
   input wire logic clk_i,
   input wire logic [prot_pkg::NUM_ELEM-1:0] fault_req_i,
   input wire logic [prot_pkg::NUM_ELEM*prot_pkg::NUM_PHASE-1:0] phase_req_i,
   input wire logic [prot_pkg::NUM_ELEM-1:0] active_req_i,
   output logic [prot_pkg::NUM_ELEM-1:0] fault_o,
   output logic [prot_pkg::NUM_ELEM*prot_pkg::NUM_PHASE-1:0] phase_o,
   output logic [prot_pkg::NUM_ELEM-1:0] active_o
);
   // Elements hold levels; a change lands one edge after the request
   initial
   begin
      fault_o = '0;
      phase_o = '0;
      active_o = '0;
   end
   always @(posedge clk_i)
   begin
      fault_o <= fault_req_i;
      phase_o <= phase_req_i;
      active_o <= active_req_i;
   end
endmodule

// ### prot_aggregator.sv
// Master general-protection alarm, trip and blocking aggregator
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ns
module prot_aggregator
#(
   parameter int NUM_ELEM = prot_pkg::NUM_ELEM,
   parameter int NUM_PHASE = prot_pkg::NUM_PHASE,
   parameter int DELAY_W = prot_pkg::DELAY_W
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire logic [NUM_ELEM-1:0] fault_i,
   input wire logic [NUM_ELEM*NUM_PHASE-1:0] fault_phase_i,
   input wire logic [NUM_ELEM-1:0] elem_active_i,
   input wire logic param_change_i,
   input wire logic meas_ok_i,
   input wire logic external_block_in_a_i,
   input wire logic external_block_in_b_i,
   input wire logic temp_trip_block_input_i,
   output logic [NUM_ELEM-1:0] elem_alarm_o,
   output logic [NUM_ELEM-1:0] elem_trip_o,
   output logic [NUM_ELEM-1:0] trip_command_o,
   output logic general_alarm_o,
   output logic general_trip_o,
   output logic [NUM_PHASE-1:0] phase_alarm_o,
   output logic [NUM_PHASE-1:0] phase_trip_o,
   output logic prot_available_o,
   output logic prot_active_o,
   output logic master_external_block_o,
   output logic irq_o
);
   // ****************************************
   // State
   // ****************************************
   localparam int SYNC_W = 2*NUM_ELEM + NUM_ELEM*NUM_PHASE + 5;
   // Bit positions inside the synchroniser word; one wide word keeps all pins in step
   localparam int SYNC_TEMP = 0;
   localparam int SYNC_BLK_B = 1;
   localparam int SYNC_BLK_A = 2;
   localparam int SYNC_MOK = 3;
   localparam int SYNC_PCHG = 4;
   localparam int SYNC_PHASE = 5;
   localparam int SYNC_ACT = SYNC_PHASE + NUM_ELEM*NUM_PHASE;
   localparam int SYNC_FAULT = SYNC_ACT + NUM_ELEM;
   typedef struct packed {
      logic [SYNC_W-1:0] sync1;
      logic [SYNC_W-1:0] sync2;
      logic [31:0] ctrl;
      logic [NUM_ELEM-1:0] superv;
      logic [NUM_ELEM-1:0] perm_blk;
      logic [NUM_ELEM-1:0] temp_permit;
      logic [NUM_ELEM-1:0] phase_cap;
      logic [NUM_ELEM-1:0] bf_elem;
      logic [DELAY_W-1:0] delay;
      logic [NUM_ELEM-1:0][DELAY_W-1:0] timer;
      logic [NUM_ELEM-1:0] alarm;
      logic [NUM_ELEM-1:0] trip;
      logic [NUM_ELEM-1:0] trip_cmd;
      prot_pkg::collective_t coll;
      logic available;
      logic active;
      logic ext_block;
      logic [prot_pkg::IRQ_W-1:0] irq_stat;
      logic [prot_pkg::IRQ_W-1:0] irq_mask;
      logic irq;
      logic [31:0] rdata;
   } state_t;
   state_t s;
   state_t next_s;
   prot_pkg::bus_req_t req;
   // ****************************************
   // Next state
   // ****************************************
   always_comb
   begin
      logic [NUM_ELEM-1:0] f;
      logic [NUM_ELEM-1:0] act;
      logic [NUM_ELEM*NUM_PHASE-1:0] fp;
      logic pc;
      logic mok;
      logic ba;
      logic bb;
      logic tb;
      logic [NUM_ELEM-1:0] fwd;
      logic [NUM_ELEM-1:0] new_alarm;
      logic [NUM_ELEM-1:0] new_trip;
      logic temp_blk;
      logic [prot_pkg::IRQ_W-1:0] ev;
      prot_pkg::collective_t c;
      f = '0;
      act = '0;
      fp = '0;
      pc = 1'b0;
      mok = 1'b0;
      ba = 1'b0;
      bb = 1'b0;
      tb = 1'b0;
      fwd = '0;
      new_alarm = '0;
      new_trip = '0;
      temp_blk = 1'b0;
      ev = '0;
      c = '0;
      req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
      next_s = s;
      // Pins cross two flip-flops; only the second stage is read
      next_s.sync1 = {fault_i, elem_active_i, fault_phase_i, param_change_i, meas_ok_i,
         external_block_in_a_i, external_block_in_b_i, temp_trip_block_input_i};
      next_s.sync2 = s.sync1;
      {f, act, fp, pc, mok, ba, bb, tb} = s.sync2;
      // Element detection: alarm at once, trip after delay with fault still present
      for (int e = 0; e < NUM_ELEM; e++)
      begin
         new_alarm[e] = f[e];
         if (!f[e])
         begin
            next_s.timer[e] = '0;
         end
         else if (s.timer[e] < s.delay)
         begin
            next_s.timer[e] = s.timer[e] + DELAY_W'(1);
         end
         new_trip[e] = f[e] && (s.timer[e] >= s.delay);
      end
      next_s.alarm = new_alarm;
      next_s.trip = new_trip;
      // Master availability and blocking
      next_s.available = !pc && mok;
      next_s.ext_block = s.ctrl[prot_pkg::CTRL_EXT_PERMIT] && (ba || bb);
      next_s.active = next_s.available && s.ctrl[prot_pkg::CTRL_ENABLE] && !next_s.ext_block;
      // Forward only non-supervision, active elements while master is active
      fwd = ~s.superv & act & {NUM_ELEM{next_s.active}};
      for (int e = 0; e < NUM_ELEM; e++)
      begin
         // Breaker-failure elements feed the general alarm even when marked supervision, but not the general trip or phase signals
         if (fwd[e] || (s.bf_elem[e] && act[e] && next_s.active))
         begin
            c.general_alarm = c.general_alarm | new_alarm[e];
         end
         if (fwd[e])
         begin
            c.general_trip = c.general_trip | new_trip[e];
         end
         if (fwd[e] && s.phase_cap[e])
         begin
            for (int p = 0; p < NUM_PHASE; p++)
            begin
               c.phase_alarm[p] = c.phase_alarm[p] | (new_alarm[e] & fp[e*NUM_PHASE+p]);
               c.phase_trip[p] = c.phase_trip[p] | (new_trip[e] & fp[e*NUM_PHASE+p]);
            end
         end
      end
      next_s.coll = c;
      // Trip command gating
      // Gating sits after the trip decision, so local trip states stay readable while blocked
      temp_blk = s.ctrl[prot_pkg::CTRL_TEMP_PERMIT] && tb;
      for (int e = 0; e < NUM_ELEM; e++)
      begin
         next_s.trip_cmd[e] = fwd[e] && new_trip[e] && !s.perm_blk[e]
            && !s.ctrl[prot_pkg::CTRL_PERM_BLOCK]
            && !(s.temp_permit[e] && temp_blk);
      end
      // Interrupt events: rising general alarm, trip, or loss of active
      ev[prot_pkg::IRQ_ALARM] = c.general_alarm && !s.coll.general_alarm;
      ev[prot_pkg::IRQ_TRIP] = c.general_trip && !s.coll.general_trip;
      ev[prot_pkg::IRQ_INACTIVE] = !next_s.active && s.active;
      next_s.rdata = '0;
      if (req.wr)
      begin
         case (req.addr)
            prot_pkg::ADDR_CTRL: next_s.ctrl = req.wdata;
            prot_pkg::ADDR_IRQ_STAT: next_s.irq_stat = s.irq_stat & ~req.wdata[prot_pkg::IRQ_W-1:0];
            prot_pkg::ADDR_IRQ_MASK: next_s.irq_mask = req.wdata[prot_pkg::IRQ_W-1:0];
            prot_pkg::ADDR_SUPERV: next_s.superv = req.wdata[NUM_ELEM-1:0];
            prot_pkg::ADDR_PERM_BLK: next_s.perm_blk = req.wdata[NUM_ELEM-1:0];
            prot_pkg::ADDR_TEMP_PERMIT: next_s.temp_permit = req.wdata[NUM_ELEM-1:0];
            prot_pkg::ADDR_PHASE_CAP: next_s.phase_cap = req.wdata[NUM_ELEM-1:0];
            prot_pkg::ADDR_BF_ELEM: next_s.bf_elem = req.wdata[NUM_ELEM-1:0];
            prot_pkg::ADDR_DELAY: next_s.delay = req.wdata[DELAY_W-1:0];
            default: ;
         endcase
      end
      // Set wins over a write-one clear in the same cycle
      next_s.irq_stat = next_s.irq_stat | ev;
      next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
      if (req.rd)
      begin
         case (req.addr)
            prot_pkg::ADDR_CTRL: next_s.rdata = s.ctrl;
            prot_pkg::ADDR_STATUS: next_s.rdata = 32'({s.coll, s.ext_block, s.active, s.available});
            prot_pkg::ADDR_IRQ_STAT: next_s.rdata = 32'(s.irq_stat);
            prot_pkg::ADDR_IRQ_MASK: next_s.rdata = 32'(s.irq_mask);
            prot_pkg::ADDR_SUPERV: next_s.rdata = 32'(s.superv);
            prot_pkg::ADDR_PERM_BLK: next_s.rdata = 32'(s.perm_blk);
            prot_pkg::ADDR_TEMP_PERMIT: next_s.rdata = 32'(s.temp_permit);
            prot_pkg::ADDR_PHASE_CAP: next_s.rdata = 32'(s.phase_cap);
            prot_pkg::ADDR_BF_ELEM: next_s.rdata = 32'(s.bf_elem);
            prot_pkg::ADDR_DELAY: next_s.rdata = 32'(s.delay);
            default: next_s.rdata = '0;
         endcase
      end
   end
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s <= '0;
         s.ctrl <= prot_pkg::CTRL_RESET;
         s.delay <= DELAY_W'(prot_pkg::DELAY_DEFAULT);
      end
      else
      begin
         s <= next_s;
      end
   end
   // ****************************************
   // Outputs
   // ****************************************
   assign rdata_o = s.rdata;
   // Local element states stay readable even for supervision-only elements
   assign elem_alarm_o = s.alarm;
   assign elem_trip_o = s.trip;
   assign trip_command_o = s.trip_cmd;
   assign general_alarm_o = s.coll.general_alarm;
   assign general_trip_o = s.coll.general_trip;
   assign phase_alarm_o = s.coll.phase_alarm;
   assign phase_trip_o = s.coll.phase_trip;
   assign prot_available_o = s.available;
   assign prot_active_o = s.active;
   assign master_external_block_o = s.ext_block;
   assign irq_o = s.irq;
   // ****************************************
   // Checks
   // ****************************************
   a_perm_block_cmd: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(s.ctrl[prot_pkg::CTRL_PERM_BLOCK]) |-> trip_command_o == '0)
      else $error("trip command while permanently blocked");
   sequence temp_block_s;
      s.ctrl[prot_pkg::CTRL_TEMP_PERMIT] && s.sync2[SYNC_TEMP];
   endsequence
   a_temp_block_cmd: assert property (@(posedge clk_i) disable iff (rst_i)
      temp_block_s |=> (trip_command_o & $past(s.temp_permit)) == '0)
      else $error("trip command while temporarily blocked");
   a_superv_no_cmd: assert property (@(posedge clk_i) disable iff (rst_i)
      (trip_command_o & $past(s.superv)) == '0)
      else $error("supervision element issued trip command");
   a_cmd_needs_trip: assert property (@(posedge clk_i) disable iff (rst_i)
      (trip_command_o & ~elem_trip_o) == '0)
      else $error("trip command without trip");
   a_general_trip_or: assert property (@(posedge clk_i) disable iff (rst_i)
      general_trip_o |-> |elem_trip_o)
      else $error("general trip without element trip");
   a_active_needs: assert property (@(posedge clk_i) disable iff (rst_i)
      prot_active_o |-> (prot_available_o && !master_external_block_o))
      else $error("active without availability");
   sequence fault_held_s;
      s.sync2[SYNC_FAULT+NUM_ELEM-1] [*2];
   endsequence
   // Local alarm state keeps following the fault whatever the supervision setting
   a_alarm_follows: assert property (@(posedge clk_i) disable iff (rst_i)
      fault_held_s |=> elem_alarm_o[NUM_ELEM-1])
      else $error("element alarm not following its fault");
   a_trip_delay: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(elem_trip_o[NUM_ELEM-1]) |-> $past(s.timer[NUM_ELEM-1]) >= $past(s.delay))
      else $error("trip before delay elapsed");
   a_ext_block: assert property (@(posedge clk_i) disable iff (rst_i)
      (s.ctrl[prot_pkg::CTRL_EXT_PERMIT] && s.sync2[SYNC_BLK_A]) |=> master_external_block_o)
      else $error("external block missing");
   a_avail_cond: assert property (@(posedge clk_i) disable iff (rst_i)
      prot_available_o |-> ($past(s.sync2[SYNC_MOK]) && !$past(s.sync2[SYNC_PCHG])))
      else $error("available without measured-value health");
   a_phase_cap: assert property (@(posedge clk_i) disable iff (rst_i)
      (|phase_trip_o) |-> (|($past(s.phase_cap) & ~$past(s.superv))))
      else $error("phase signal from incapable element");
   a_ext_block_b: assert property (@(posedge clk_i) disable iff (rst_i)
      (s.ctrl[prot_pkg::CTRL_EXT_PERMIT] && s.sync2[SYNC_BLK_B]) |=> master_external_block_o)
      else $error("second external block input ignored");
   a_ext_needs_permit: assert property (@(posedge clk_i) disable iff (rst_i)
      master_external_block_o |-> $past(s.ctrl[prot_pkg::CTRL_EXT_PERMIT]))
      else $error("external block without permission");
   a_avail_pchg: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(s.sync2[SYNC_PCHG]) |-> !prot_available_o)
      else $error("available during parameter change");
   a_active_enable: assert property (@(posedge clk_i) disable iff (rst_i)
      prot_active_o |-> $past(s.ctrl[prot_pkg::CTRL_ENABLE]))
      else $error("active while master disabled");
   a_general_alarm_or: assert property (@(posedge clk_i) disable iff (rst_i)
      general_alarm_o |-> |elem_alarm_o)
      else $error("general alarm without element alarm");
   a_superv_excluded: assert property (@(posedge clk_i) disable iff (rst_i)
      general_trip_o |-> |(elem_trip_o & ~$past(s.superv)))
      else $error("general trip from supervision element only");
   a_trip_active: assert property (@(posedge clk_i) disable iff (rst_i)
      general_trip_o |-> (prot_active_o && |(elem_trip_o & $past(s.sync2[SYNC_ACT +: NUM_ELEM]))))
      else $error("general trip from inactive element");
   a_cmd_general: assert property (@(posedge clk_i) disable iff (rst_i)
      (|trip_command_o) |-> general_trip_o)
      else $error("trip command without general trip");
   a_perm_elem_block: assert property (@(posedge clk_i) disable iff (rst_i)
      (trip_command_o & $past(s.perm_blk)) == '0)
      else $error("trip command of permanently blocked element");
   a_cmd_delay: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(trip_command_o[NUM_ELEM-1]) |-> $past(s.timer[NUM_ELEM-1]) >= $past(s.delay))
      else $error("trip command before delay elapsed");
   a_phase_alarm_or: assert property (@(posedge clk_i) disable iff (rst_i)
      (|phase_alarm_o) |-> general_alarm_o)
      else $error("phase alarm without forwarded alarm");
   a_phase_trip_or: assert property (@(posedge clk_i) disable iff (rst_i)
      (|phase_trip_o) |-> general_trip_o)
      else $error("phase trip without forwarded trip");
   // ****************************************
   // Interrupt and bus checks
   // ****************************************
   a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
      irq_o == |(s.irq_stat & s.irq_mask))
      else $error("interrupt level differs from status and mask");
   a_inactive_irq: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(prot_active_o) |-> s.irq_stat[prot_pkg::IRQ_INACTIVE])
      else $error("loss of active not latched");
   a_rdata_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      !$past(rd_i) |-> rdata_o == '0)
      else $error("read data outside read answer cycle");
endmodule

// ### prot_pkg.sv
// Package with constants and carrier types for the protection aggregator
package prot_pkg;
   localparam int NUM_ELEM = 4;
   localparam int NUM_PHASE = 3;
   localparam int DELAY_W = 16;
   localparam logic [15:0] DELAY_DEFAULT = 16'h0004;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
   localparam logic [7:0] ADDR_SUPERV = 8'h10;
   localparam logic [7:0] ADDR_PERM_BLK = 8'h14;
   localparam logic [7:0] ADDR_TEMP_PERMIT = 8'h18;
   localparam logic [7:0] ADDR_PHASE_CAP = 8'h1C;
   localparam logic [7:0] ADDR_BF_ELEM = 8'h20;
   localparam logic [7:0] ADDR_DELAY = 8'h24;
   localparam int CTRL_ENABLE = 0;
   localparam int CTRL_EXT_PERMIT = 1;
   localparam int CTRL_TEMP_PERMIT = 2;
   localparam int CTRL_PERM_BLOCK = 3;
   localparam int IRQ_ALARM = 0;
   localparam int IRQ_TRIP = 1;
   localparam int IRQ_INACTIVE = 2;
   localparam int IRQ_W = 3;
   localparam logic [31:0] CTRL_RESET = 32'h00000001;
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;
   typedef struct packed {
      logic general_alarm;
      logic general_trip;
      logic [NUM_PHASE-1:0] phase_alarm;
      logic [NUM_PHASE-1:0] phase_trip;
   } collective_t;
endpackage

// ### tb.sv
// Self-checking testbench of the protection aggregator
`timescale 1ns/1ns
module tb;
   logic clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, pc = 1'b0, mok = 1'b1;
   logic exa = 1'b0, exb = 1'b0, tbk = 1'b0, ga, gt, avail, pact, mext, irq;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h00000000, rdata_o, rv;
   logic [3:0] flt = 4'h0, act = 4'h0, sup = 4'h0, perm = 4'h0, tp = 4'h0, cap = 4'h0, bf = 4'h0, ctrl = 4'h1;
   logic [3:0] fp, ap, ea, et, tc, acc;
   logic [11:0] ph = 12'h000, pp;
   logic [2:0] pa, pt;
   int error_cnt = 0, tests_run = 0, cyc = 0;
   always #25 clk_i = ~clk_i;
   elem_model model (.clk_i(clk_i), .fault_req_i(flt), .phase_req_i(ph), .active_req_i(act),
      .fault_o(fp), .phase_o(pp), .active_o(ap));
   prot_aggregator dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .fault_i(fp), .fault_phase_i(pp), .elem_active_i(ap),
      .param_change_i(pc), .meas_ok_i(mok), .external_block_in_a_i(exa), .external_block_in_b_i(exb),
      .temp_trip_block_input_i(tbk), .elem_alarm_o(ea), .elem_trip_o(et), .trip_command_o(tc),
      .general_alarm_o(ga), .general_trip_o(gt), .phase_alarm_o(pa), .phase_trip_o(pt),
      .prot_available_o(avail), .prot_active_o(pact), .master_external_block_o(mext), .irq_o(irq));
   // ****************************************
   // Expectations
   // ****************************************
   function logic e_avail();
      return !pc && mok;
   endfunction
   function logic e_ext();
      return ctrl[1] && (exa || exb);
   endfunction
   function logic e_act();
      return e_avail() && ctrl[0] && !e_ext();
   endfunction
   function logic e_ga();
      return e_act() && ((flt & act & (~sup | bf)) != 4'h0);
   endfunction
   function logic e_gt();
      return e_act() && ((flt & ~sup & act) != 4'h0);
   endfunction
   function logic [2:0] e_phase();
      logic [2:0] r;
      r = 3'h0;
      for (int e = 0; e < 4; e++)
         for (int p = 0; p < 3; p++)
            r[p] |= cap[e] & ~sup[e] & act[e] & flt[e] & ph[e*3+p];
      return e_act() ? r : 3'h0;
   endfunction
   function logic [3:0] e_cmd();
      return (e_act() && !ctrl[3]) ? (flt & ~sup & act & ~perm & ~({4{tbk & ctrl[2]}} & tp)) : 4'h0;
   endfunction
   // ****************************************
   // Bus, compare and closing tasks
   // ****************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   task automatic test_done();
      if (error_cnt == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         test_done();
      end
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      void'($urandom(67563));
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      chk({ea, et, tc, ga, gt, avail, pact, mext}, 32'h0);
      for (int i = 0; i < 11; i++)
      begin
         rd_reg(8'(4 * i), rv);
         chk(rv, (i == 0) ? 32'h1 : (i == 9) ? 32'h4 : (i == 1) ? 32'h3 : 32'h0);
      end
      rd_reg(8'h40, rv);
      chk(rv, 32'h0);
      // Fault shorter than the timer must never trip
      wr_reg(prot_pkg::ADDR_DELAY, 32'h8);
      act <= 4'hF;
      flt <= 4'h1;
      acc = 4'h0;
      repeat (4) @(posedge clk_i);
      flt <= 4'h0;
      repeat (20) @(posedge clk_i) acc |= et;
      chk(acc, 4'h0);
      flt <= 4'h1;
      repeat (6) @(posedge clk_i);
      chk({ea[0], et[0]}, 2'b10);
      repeat (12) @(posedge clk_i);
      chk({et[0], gt, tc[0]}, 3'b111);
      // Interrupt raised, read, cleared and masked
      flt <= 4'h0;
      wr_reg(prot_pkg::ADDR_DELAY, 32'h2);
      repeat (8) @(posedge clk_i);
      wr_reg(prot_pkg::ADDR_IRQ_STAT, 32'h7);
      wr_reg(prot_pkg::ADDR_IRQ_MASK, 32'h1);
      chk(irq, 1'b0);
      flt <= 4'h2;
      repeat (8) @(posedge clk_i);
      chk(irq, 1'b1);
      rd_reg(prot_pkg::ADDR_IRQ_STAT, rv);
      chk(rv[0], 1'b1);
      flt <= 4'h0;
      repeat (8) @(posedge clk_i);
      chk(irq, 1'b1);
      wr_reg(prot_pkg::ADDR_IRQ_STAT, 32'h7);
      @(posedge clk_i);
      chk(irq, 1'b0);
      wr_reg(prot_pkg::ADDR_IRQ_MASK, 32'h0);
      flt <= 4'h2;
      repeat (8) @(posedge clk_i);
      chk(irq, 1'b0);
      // Random configurations and pin states
      for (int n = 0; n < 60; n++)
      begin
         {sup, perm, cap, bf} = 16'($urandom);
         ctrl = 4'($urandom) | ((n % 4 == 0) ? 4'h5 : 4'h1);
         tp = 4'($urandom);
         wr_reg(prot_pkg::ADDR_SUPERV, 32'(sup));
         wr_reg(prot_pkg::ADDR_PERM_BLK, 32'(perm));
         wr_reg(prot_pkg::ADDR_TEMP_PERMIT, 32'(tp));
         wr_reg(prot_pkg::ADDR_PHASE_CAP, 32'(cap));
         wr_reg(prot_pkg::ADDR_BF_ELEM, 32'(bf));
         wr_reg(prot_pkg::ADDR_CTRL, 32'(ctrl));
         {flt, act, ph} <= 20'($urandom);
         {exa, exb, tbk} <= 3'($urandom);
         pc <= ($urandom % 5) == 0;
         mok <= ($urandom % 5) != 0;
         repeat (12) @(posedge clk_i);
         chk({avail, pact}, {e_avail(), e_act()});
         chk(mext, e_ext());
         chk(ga, e_ga());
         chk(gt, e_gt());
         chk({pa, pt}, {e_phase(), e_phase()});
         chk(tc, e_cmd());
         chk({ea, et}, {flt, flt});
         rd_reg(prot_pkg::ADDR_STATUS, rv);
         chk(rv, 32'({e_ga(), e_gt(), e_phase(), e_phase(), e_ext(), e_act(), e_avail()}));
      end
      test_done();
   end
endmodule
